// File: core/wdt_pkg.sv
// constants, offsets and reset values shared by the watchdog files
package wdt_pkg;

    localparam logic [11:0] OFS_LOAD     = 12'h000;
    localparam logic [11:0] OFS_VALUE    = 12'h004;
    localparam logic [11:0] OFS_CONTROL  = 12'h008;
    localparam logic [11:0] OFS_INTCLR   = 12'h00c;
    localparam logic [11:0] OFS_RIS      = 12'h010;
    localparam logic [11:0] OFS_MIS      = 12'h014;
    localparam logic [11:0] OFS_LOCK     = 12'hc00;
    localparam logic [11:0] OFS_ITCR     = 12'hf00;
    localparam logic [11:0] OFS_ITOP     = 12'hf04;
    localparam logic [11:0] OFS_PID4     = 12'hfd0;
    localparam logic [11:0] OFS_PID5     = 12'hfd4;
    localparam logic [11:0] OFS_PID6     = 12'hfd8;
    localparam logic [11:0] OFS_PID7     = 12'hfdc;
    localparam logic [11:0] OFS_PID0     = 12'hfe0;
    localparam logic [11:0] OFS_PID1     = 12'hfe4;
    localparam logic [11:0] OFS_PID2     = 12'hfe8;
    localparam logic [11:0] OFS_PID3     = 12'hfec;
    localparam logic [11:0] OFS_CID0     = 12'hff0;
    localparam logic [11:0] OFS_CID1     = 12'hff4;
    localparam logic [11:0] OFS_CID2     = 12'hff8;
    localparam logic [11:0] OFS_CID3     = 12'hffc;

    localparam logic [31:0] LOCK_KEY     = 32'h1acce551;

    // field positions
    localparam int CTRL_IRQ_ENABLE_BIT_BIT        = 0;
    localparam int CTRL_RESET_ENABLE_BIT_BIT        = 1;
    localparam int ITCR_MODE_BIT         = 0;
    localparam int ITOP_RES_BIT          = 0;
    localparam int ITOP_INT_BIT          = 1;

    // values after reset
    localparam logic [31:0] RST_LOAD     = 32'hffffffff;
    localparam logic [1:0]  RST_CTRL     = 2'h0;
    localparam logic        RST_LOCK     = 1'b0;
    localparam logic        RST_ITCR     = 1'b0;
    localparam logic [1:0]  RST_ITOP     = 2'h0;
    localparam logic [31:0] RST_VALUE    = 32'hffffffff;

    // identification bytes: values are arbitrary, not any maker's code
    localparam logic [7:0] ID_PID0       = 8'h11;
    localparam logic [7:0] ID_PID1       = 8'h22;
    localparam logic [7:0] ID_PID2       = 8'h33;
    localparam logic [7:0] ID_PID4       = 8'h44;
    localparam logic [7:0] ID_PID_UNUSED = 8'h00;
    localparam logic [3:0] ID_CUST_MOD   = 4'h0;
    localparam logic [7:0] ID_CID0       = 8'h55;
    localparam logic [7:0] ID_CID1       = 8'h66;
    localparam logic [7:0] ID_CID2       = 8'h77;
    localparam logic [7:0] ID_CID3       = 8'h88;

    typedef struct packed {
        logic [31:0] load;
        logic [1:0]  ctrl;
        logic        lock;
        logic        itcr;
        logic [1:0]  itop;
        logic [31:0] rdata;
    } wdt_regs_t;

    typedef struct packed {
        logic [31:0] value;
        logic        ris;
        logic        res;
    } wdt_cnt_t;

endpackage

// File: core/wdt_counter.sv
// watchdog countdown, raw interrupt and raw timeout reset
`timescale 1ns/1ps
module wdt_counter
    import wdt_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_counter_domain_reset_n,
    input  wire logic        i_counter_clock_enable,
    input  wire logic        i_run,
    input  wire logic [31:0] i_load_value,
    input  wire logic        i_reload,
    input  wire logic        i_irq_clear,
    output logic      [31:0] o_value,
    output logic             o_raw_irq,
    output logic             o_raw_reset
);

    wdt_cnt_t cnt_r;
    wdt_cnt_t cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (i_irq_clear) begin
            cnt_nxt.ris = 1'b0;
        end
        if (i_reload || i_irq_clear) begin
            cnt_nxt.value = i_load_value;
        end else if (i_counter_clock_enable && i_run) begin
            if (cnt_r.value == 32'h0) begin
                // a second timeout with the irq still pending fires the reset
                if (cnt_r.ris) begin
                    cnt_nxt.res = 1'b1;
                end
                cnt_nxt.ris   = 1'b1;
                cnt_nxt.value = i_load_value;
            end else begin
                cnt_nxt.value = cnt_r.value - 32'h1;
            end
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_counter_domain_reset_n) begin
        if (!i_counter_domain_reset_n) begin
            cnt_r <= '{value: RST_VALUE, ris: 1'b0, res: 1'b0};
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign o_value     = cnt_r.value;
    assign o_raw_irq   = cnt_r.ris;
    assign o_raw_reset = cnt_r.res;

endmodule

// File: core/wdt_top.sv
// watchdog register slave, test output override and output gating
`timescale 1ns/1ps
module wdt_top
    import wdt_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_sys_rst,
    input  wire logic        i_counter_domain_reset_n,
    input  wire logic        i_counter_clock_enable,
    input  wire logic [3:0]  i_eco_revision_in,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:2] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_timeout_irq_out,
    output logic             o_timeout_reset_out
);

    wdt_regs_t   reg_r;
    wdt_regs_t   reg_nxt;
    logic [11:0] byte_addr;
    logic        wr_access;
    logic        wr_allowed;
    logic        rd_setup;
    logic        load_wr;
    logic        irq_enable_bit_rise;
    logic        clear_wr;
    logic        cnt_reload;
    logic [31:0] cnt_value;
    logic        raw_irq;
    logic        raw_reset;
    logic        masked_irq;
    logic        gated_reset;
    logic [31:0] rd_word;

    assign byte_addr = {i_paddr, 2'b00};
    assign wr_access = i_psel && i_penable && i_pwrite;
    assign rd_setup  = i_psel && !i_penable && !i_pwrite;
    assign wr_allowed = wr_access && !reg_r.lock;

    assign load_wr    = wr_allowed && (byte_addr == OFS_LOAD);
    assign clear_wr   = wr_allowed && (byte_addr == OFS_INTCLR);
    assign irq_enable_bit_rise = wr_allowed && (byte_addr == OFS_CONTROL)
                        && i_pwdata[CTRL_IRQ_ENABLE_BIT_BIT] && !reg_r.ctrl[CTRL_IRQ_ENABLE_BIT_BIT];
    assign cnt_reload = load_wr || irq_enable_bit_rise;

    // counter shares the bus clock, so no crossing here
    wdt_counter u_counter (
        .i_clk_sys                (i_clk_sys),
        .i_counter_domain_reset_n (i_counter_domain_reset_n),
        .i_counter_clock_enable   (i_counter_clock_enable),
        .i_run                    (reg_r.ctrl[CTRL_IRQ_ENABLE_BIT_BIT]),
        .i_load_value             (load_wr ? i_pwdata : reg_r.load),
        .i_reload                 (cnt_reload),
        .i_irq_clear              (clear_wr),
        .o_value                  (cnt_value),
        .o_raw_irq                (raw_irq),
        .o_raw_reset              (raw_reset)
    );

    assign masked_irq  = raw_irq && reg_r.ctrl[CTRL_IRQ_ENABLE_BIT_BIT];
    assign gated_reset = raw_reset && reg_r.ctrl[CTRL_RESET_ENABLE_BIT_BIT];

    // read word chosen in the setup phase, held in a flop for the access phase
    always_comb begin
        rd_word = 32'h0;
        unique case (byte_addr)
            OFS_LOAD:    rd_word = reg_r.load;
            OFS_VALUE:   rd_word = cnt_value;
            OFS_CONTROL: rd_word = {30'h0, reg_r.ctrl};
            OFS_RIS:     rd_word = {31'h0, raw_irq};
            OFS_MIS:     rd_word = {31'h0, masked_irq};
            OFS_LOCK:    rd_word = {31'h0, reg_r.lock};
            OFS_ITCR:    rd_word = {31'h0, reg_r.itcr};
            OFS_PID0:    rd_word = {24'h0, ID_PID0};
            OFS_PID1:    rd_word = {24'h0, ID_PID1};
            OFS_PID2:    rd_word = {24'h0, ID_PID2};
            OFS_PID3:    rd_word = {24'h0, i_eco_revision_in, ID_CUST_MOD};
            OFS_PID4:    rd_word = {24'h0, ID_PID4};
            OFS_PID5,
            OFS_PID6,
            OFS_PID7:    rd_word = {24'h0, ID_PID_UNUSED};
            OFS_CID0:    rd_word = {24'h0, ID_CID0};
            OFS_CID1:    rd_word = {24'h0, ID_CID1};
            OFS_CID2:    rd_word = {24'h0, ID_CID2};
            OFS_CID3:    rd_word = {24'h0, ID_CID3};
            // write-only and unmapped offsets read zero
            default:     rd_word = 32'h0;
        endcase
    end

    always_comb begin
        reg_nxt = reg_r;
        if (rd_setup) begin
            reg_nxt.rdata = rd_word;
        end
        if (wr_access && (byte_addr == OFS_LOCK)) begin
            reg_nxt.lock = (i_pwdata != LOCK_KEY);
        end
        if (wr_allowed) begin
            unique case (byte_addr)
                OFS_LOAD:    reg_nxt.load = i_pwdata;
                OFS_CONTROL: reg_nxt.ctrl = i_pwdata[1:0];
                OFS_ITCR:    reg_nxt.itcr = i_pwdata[ITCR_MODE_BIT];
                OFS_ITOP:    reg_nxt.itop = i_pwdata[1:0];
                default:     reg_nxt.itop = reg_r.itop;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            reg_r <= '{load: RST_LOAD, ctrl: RST_CTRL, lock: RST_LOCK, itcr: RST_ITCR,
                       itop: RST_ITOP, rdata: 32'h0};
        end else begin
            reg_r <= reg_nxt;
        end
    end

    // outputs mux straight from flops so leaving test mode takes effect the same cycle
    always_comb begin
        if (reg_r.itcr) begin
            o_timeout_irq_out   = reg_r.itop[ITOP_INT_BIT];
            o_timeout_reset_out = reg_r.itop[ITOP_RES_BIT];
        end else begin
            o_timeout_irq_out   = masked_irq;
            o_timeout_reset_out = gated_reset;
        end
    end

    assign o_prdata  = reg_r.rdata;
    assign o_pready  = 1'b1;
    assign o_pslverr = 1'b0;

endmodule

// File: tb/wdt_monitor.sv
// checker for the watchdog ports
`timescale 1ns/1ps
module wdt_monitor
    import wdt_pkg::*;
(
    input wire logic        i_clk_sys,
    input wire logic        i_sys_rst,
    input wire logic [3:0]  i_eco_revision_in,
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [11:2] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic        o_timeout_irq_out,
    input wire logic        o_timeout_reset_out
);
    logic        tm_r;
    logic        lk_r;
    logic [1:0]  op_r;
    logic [1:0]  ct_r;
    logic [11:0] adr;
    logic        wr;
    logic        rd;
    assign adr = {i_paddr, 2'b00};
    assign wr = i_psel & i_penable & i_pwrite;
    assign rd = i_psel & ~i_penable & ~i_pwrite;
    // shadow bits follow the lock, as software sees them
    always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            {tm_r, lk_r, op_r, ct_r} <= '0;
        end else if (wr && adr == OFS_LOCK) begin
            lk_r <= (i_pwdata != LOCK_KEY);
        end else if (wr && !lk_r) begin
            case (adr)
                OFS_ITCR: tm_r <= i_pwdata[0];
                OFS_ITOP: op_r <= i_pwdata[1:0];
                OFS_CONTROL: ct_r <= i_pwdata[1:0];
                default: ;
            endcase
        end
    end
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    property p_ti; tm_r |-> o_timeout_irq_out == op_r[1]; endproperty
    a_ti: assert property (p_ti) else $error("test irq");
    property p_tr; tm_r |-> o_timeout_reset_out == op_r[0]; endproperty
    a_tr: assert property (p_tr) else $error("test reset");
    property p_cr; rd && adr == OFS_ITCR |=> o_prdata == {31'h0, tm_r}; endproperty
    a_cr: assert property (p_cr) else $error("itcr read");
    property p_or; rd && adr == OFS_ITOP |=> o_prdata[31:2] == 30'h0; endproperty
    a_or: assert property (p_or) else $error("itop read");
    property p_eco; rd && adr == OFS_PID3 |=> o_prdata[7:4] == $past(i_eco_revision_in); endproperty
    a_eco: assert property (p_eco) else $error("eco field");
    property p_lk; rd && adr == OFS_LOCK |=> o_prdata == {31'h0, lk_r}; endproperty
    a_lk: assert property (p_lk) else $error("lock read");
    property p_im; !tm_r && !ct_r[0] |-> !o_timeout_irq_out; endproperty
    a_im: assert property (p_im) else $error("irq mask");
    property p_rm; !tm_r && !ct_r[1] |-> !o_timeout_reset_out; endproperty
    a_rm: assert property (p_rm) else $error("reset mask");
endmodule
bind wdt_top wdt_monitor i_wdt_monitor (.i_clk_sys, .i_sys_rst, .i_eco_revision_in, .i_psel, .i_penable,
    .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_timeout_irq_out, .o_timeout_reset_out);

// File: tb/wdt_apb_master.sv
// bus master standing in for the bridge
`timescale 1ns/1ps
module wdt_apb_master (
    // same clock as the counter, no crossing
    input  wire logic        i_clk_sys,
    input  wire logic        i_pready,
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic [11:2]      o_paddr,
    output logic [31:0]      o_pwdata
);
    initial begin
        {o_psel, o_penable, o_pwrite, o_paddr, o_pwdata} = '0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(negedge i_clk_sys);
        {o_psel, o_pwrite, o_paddr, o_pwdata} = {1'b1, w, a[11:2], d};
        @(negedge i_clk_sys);
        o_penable = 1'b1;
        n = 0;
        @(posedge i_clk_sys);
        while (i_pready !== 1'b1 && n < 8) begin
            n++;
            @(posedge i_clk_sys);
        end
        if (i_pready !== 1'b1) begin
            wdt_test.err_count++;
            wdt_test.complete_run();
        end
        @(negedge i_clk_sys);
        // released address and data lines must not keep their last value
        {o_psel, o_penable, o_paddr, o_pwdata} = {2'b00, ~o_paddr, ~o_pwdata};
    endtask
endmodule

// File: tb/wdt_test.sv
// self-checking bench for the watchdog test outputs and counter
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module wdt_test
    import wdt_pkg::*;
;
    logic        i_clk_sys, i_sys_rst, i_counter_domain_reset_n, i_counter_clock_enable;
    logic        i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_timeout_irq_out, o_timeout_reset_out;
    logic [3:0]  i_eco_revision_in;
    logic [11:2] i_paddr;
    logic [31:0] i_pwdata, o_prdata, seed, v, got;
    int          err_count, checks_done, n;
    logic [31:0] expq[$];
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    wdt_top i_wdt_top (.i_clk_sys, .i_sys_rst, .i_counter_domain_reset_n, .i_counter_clock_enable,
        .i_eco_revision_in, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready,
        .o_pslverr, .o_timeout_irq_out, .o_timeout_reset_out);
    wdt_apb_master i_wdt_apb_master (.i_clk_sys, .i_pready(o_pready), .o_psel(i_psel),
        .o_penable(i_penable), .o_pwrite(i_pwrite), .o_paddr(i_paddr), .o_pwdata(i_pwdata));
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        i_wdt_apb_master.xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        i_wdt_apb_master.xfer(1'b0, a, 32'h0);
    endtask
    task automatic outs(input logic [1:0] e);
        `CHK({o_timeout_irq_out, o_timeout_reset_out}, e)
    endtask
    // read results are taken off the queue in issue order
    always @(posedge i_clk_sys) begin
        if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1) begin
            got = (expq.size() > 0) ? expq.pop_front() : 32'hdeadbeef;
            `CHK(o_prdata, got)
            `CHK(o_pslverr, 1'b0)
        end
    end
    task automatic complete_run();
        $display("mismatches %0d, comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        seed = 32'h0bfbaec5;
        {i_sys_rst, i_counter_domain_reset_n, i_counter_clock_enable, i_eco_revision_in} = 7'h40;
        repeat (20) @(negedge i_clk_sys);
        {i_sys_rst, i_counter_domain_reset_n} = 2'b01;
        for (n = 0; n < 3; n++) begin
            i_eco_revision_in = 4'($random(seed));
            rd(OFS_PID3, {24'h0, i_eco_revision_in, ID_CUST_MOD});
        end
        wr(OFS_ITCR, 32'($random(seed)) | 32'h1);
        rd(OFS_ITCR, 32'h1);
        for (n = 0; n < 4; n++) begin
            wr(OFS_ITOP, 32'(n) | 32'($random(seed)) & 32'hfffffffc);
            outs(2'(n));
        end
        rd(OFS_ITOP, 32'h0);
        v = 32'($random(seed));
        // setting bit 0 of the xor term keeps the value off the key whatever v is
        wr(OFS_LOCK, LOCK_KEY ^ (v | 32'h1));
        rd(OFS_LOCK, 32'h1);
        wr(OFS_ITCR, 32'h0);
        outs(2'h3);
        wr(OFS_LOCK, LOCK_KEY);
        rd(OFS_LOCK, 32'h0);
        wr(OFS_ITCR, 32'h0);
        outs(2'h0);
        wr(OFS_LOAD, 32'h3);
        wr(OFS_CONTROL, 32'h1);
        repeat (20) @(negedge i_clk_sys);
        outs(2'h0);
        rd(OFS_VALUE, 32'h3);
        i_counter_clock_enable = 1'b1;
        n = 0;
        while (o_timeout_irq_out !== 1'b1 && n < 20) begin
            n++;
            @(negedge i_clk_sys);
        end
        // a timeout that never comes counts as a mismatch
        if (n == 20) begin
            err_count++;
            complete_run();
        end
        outs(2'h2);
        rd(OFS_MIS, 32'h1);
        repeat (10) @(negedge i_clk_sys);
        outs(2'h2);
        wr(OFS_CONTROL, 32'h3);
        outs(2'h3);
        // both raw flags stay set, so leaving test mode must show them again
        wr(OFS_ITCR, 32'h1);
        wr(OFS_ITOP, 32'h0);
        outs(2'h0);
        wr(OFS_ITCR, 32'h0);
        outs(2'h3);
        i_counter_domain_reset_n = 1'b0;
        @(negedge i_clk_sys);
        outs(2'h0);
        rd(OFS_VALUE, RST_VALUE);
        rd(OFS_CONTROL, 32'h3);
        `CHK(expq.size(), 0)
        complete_run();
    end
endmodule
